// ==== rtl/um3w_decode.sv ====
// Upstream memory window 3 registers and forwarding decision
`timescale 1ns/1ps
`include "um3w_defs.svh"
module um3w_decode (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Configuration space access
  input wire um3w_pkg::um3w_cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata,
  // Setup port shared by EEPROM, SMBus and local processor
  input wire um3w_pkg::um3w_csr_req_t csr_req,
  output logic [31:0] csr_rdata,
  // Prefetch strap for the read-only flag, and downstream window 3 range
  input wire logic prefetch_strap,
  input wire logic [63:0] ds_mem3_base,
  input wire logic [63:0] ds_mem3_limit,
  // Secondary memory transaction
  input wire um3w_pkg::um3w_txn_t sec_txn,
  output logic fwd_valid,
  output logic fwd_hit,
  output logic fwd_upstream
);
  // Register state
  logic [31:0] lower_setup_reg;
  logic [31:0] upper_setup_reg;
  logic [31:0] lower_base_reg;
  logic [31:0] upper_base_reg;
  logic fwd64_reg;
  logic prefetch_reg;

  // Output flops
  logic [31:0] cfg_rdata_reg;
  logic [31:0] csr_rdata_reg;
  logic fwd_valid_reg;
  logic fwd_hit_reg;
  logic fwd_up_reg;

  // Writable-bit mask derived from a setup register
  function automatic logic [31:0] wr_mask(input logic [31:0] setup,
                                           input logic [31:0] ro);
    wr_mask = setup & ~ro;
  endfunction : wr_mask

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // Enables, type code and writable masks
  wire lower_en = lower_setup_reg[`UM3W_SETUP_EN_BIT];
  wire upper_en = upper_setup_reg[`UM3W_SETUP_EN_BIT];
  wire win64 = fwd64_reg & upper_en;
  wire [1:0] type_fld = win64 ? `UM3W_TYPE_64 : `UM3W_TYPE_32;
  wire [31:0] lo_mask = wr_mask(lower_setup_reg, `UM3W_LOWER_RO_MASK);
  wire [31:0] hi_mask = wr_mask(upper_setup_reg, 32'h00000000);
  // Space indicator bit 0 is always 0: memory only
  wire [31:0] lower_view = {lower_base_reg[31:12], 8'h00, prefetch_reg,
                            type_fld, 1'b0};

  // Offset selects, shared by the write strobes and the read muxes
  wire cfg_sel_lo = cfg_req.addr == `UM3W_OFF_LOWER_BASE;
  wire cfg_sel_hi = cfg_req.addr == `UM3W_OFF_UPPER_BASE;
  wire cfg_sel_fw = cfg_req.addr == `UM3W_OFF_FWD_CTRL;
  wire csr_sel_lo = csr_req.addr == `UM3W_CSR_LOWER_SETUP;
  wire csr_sel_hi = csr_req.addr == `UM3W_CSR_UPPER_SETUP;

  wire cfg_lo_wr = cfg_req.wr && cfg_sel_lo;
  wire cfg_hi_wr = cfg_req.wr && cfg_sel_hi;
  wire cfg_fw_wr = cfg_req.wr && cfg_sel_fw;
  wire csr_lo_wr = csr_req.wr && csr_sel_lo;
  wire csr_hi_wr = csr_req.wr && csr_sel_hi;

  // Forwarding control word: only the 64-bit enable is kept here
  wire [31:0] fwd_view = {10'h000, fwd64_reg, 21'h000000};
  wire [31:0] cfg_rd_mux =
    cfg_sel_lo ? lower_view :
    cfg_sel_hi ? upper_base_reg :
    cfg_sel_fw ? fwd_view : 32'h00000000;
  wire [31:0] csr_rd_mux =
    csr_sel_lo ? lower_setup_reg :
    csr_sel_hi ? upper_setup_reg : 32'h00000000;

  // Masked compare, used once for each half of the 64-bit address
  function automatic logic masked_eq(input logic [31:0] a,
                                     input logic [31:0] b,
                                     input logic [31:0] m);
    masked_eq = (a & m) == (b & m);
  endfunction : masked_eq

  // Inclusive range test on a 64-bit address
  function automatic logic in_range(input logic [63:0] a,
                                    input logic [63:0] lo,
                                    input logic [63:0] hi);
    in_range = a >= lo && a <= hi;
  endfunction : in_range

  // Window match: lower half always, upper half against the base as a 64-bit window, else it must be zero
  wire [31:0] lo_cmp_base = {lower_base_reg[31:12], 12'h000};
  wire lo_match = masked_eq(sec_txn.addr[31:0], lo_cmp_base, lo_mask);
  wire hi_match = masked_eq(sec_txn.addr[63:32], upper_base_reg,
                            upper_setup_reg);
  wire addr_hi_zero = sec_txn.addr[63:32] == 32'h00000000;
  wire hi_ok = win64 ? hi_match : addr_hi_zero;
  wire in_window = lower_en && hi_ok && lo_match;
  wire in_ds = in_range(sec_txn.addr, ds_mem3_base, ds_mem3_limit);
  wire go_up = in_window || (sec_txn.dac && !in_ds);

  // Setup registers take a whole word from the setup port
  wire [31:0] lower_setup_next =
    csr_lo_wr ? csr_req.wdata : lower_setup_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lower_setup_reg <= `UM3W_SETUP_RESET;
    end else begin
      lower_setup_reg <= lower_setup_next;
    end
  end

  wire [31:0] upper_setup_next =
    csr_hi_wr ? csr_req.wdata : upper_setup_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_setup_reg <= `UM3W_SETUP_RESET;
    end else begin
      upper_setup_reg <= upper_setup_next;
    end
  end

  // Base registers take only the bits that the setup word opens
  wire [31:0] lower_base_next = cfg_lo_wr ?
    merge(lower_base_reg, cfg_req.wdata, lo_mask) : lower_base_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lower_base_reg <= `UM3W_BASE_RESET;
    end else begin
      lower_base_reg <= lower_base_next;
    end
  end

  wire [31:0] upper_base_next = cfg_hi_wr ?
    merge(upper_base_reg, cfg_req.wdata, hi_mask) : upper_base_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_base_reg <= `UM3W_BASE_RESET;
    end else begin
      upper_base_reg <= upper_base_next;
    end
  end

  wire fwd64_next =
    cfg_fw_wr ? cfg_req.wdata[`UM3W_FWD_BIT_64] : fwd64_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd64_reg <= 1'b0;
    end else begin
      fwd64_reg <= fwd64_next;
    end
  end

  // Strap is resampled by a clocked process on every clock after reset release
  wire prefetch_next = prefetch_strap;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prefetch_reg <= 1'b0;
    end else begin
      prefetch_reg <= prefetch_next;
    end
  end

  // Read data and forwarding results stand one cycle after the request
  wire [31:0] cfg_rdata_next = cfg_req.rd ? cfg_rd_mux : 32'h00000000;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_reg <= 32'h00000000;
    end else begin
      cfg_rdata_reg <= cfg_rdata_next;
    end
  end

  wire [31:0] csr_rdata_next = csr_rd_mux;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      csr_rdata_reg <= 32'h00000000;
    end else begin
      csr_rdata_reg <= csr_rdata_next;
    end
  end

  wire fwd_valid_next = sec_txn.valid;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_valid_reg <= 1'b0;
    end else begin
      fwd_valid_reg <= fwd_valid_next;
    end
  end

  wire fwd_hit_next = sec_txn.valid && in_window;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_hit_reg <= 1'b0;
    end else begin
      fwd_hit_reg <= fwd_hit_next;
    end
  end

  wire fwd_up_next = sec_txn.valid && go_up;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_up_reg <= 1'b0;
    end else begin
      fwd_up_reg <= fwd_up_next;
    end
  end

  assign cfg_rdata = cfg_rdata_reg;
  assign csr_rdata = csr_rdata_reg;
  assign fwd_valid = fwd_valid_reg;
  assign fwd_hit = fwd_hit_reg;
  assign fwd_upstream = fwd_up_reg;
endmodule : um3w_decode

// ==== rtl/um3w_defs.svh ====
// Offsets, field positions and reset values of upstream memory window 3
// Operation
// - Type field reads 00 or 01, resets 00
// - Bit 3 read-only prefetch flag, resets 0
// - Memory space only, size 4KB to 9EB
// - Lower base size/type from setup at 034h (type here from forwarding bit 21 and 038h bit 31)
// - Upper base size from setup at 038h
// - Setup bit 31 zero disables the window
// - Setup loadable by EEPROM, SMBus or processor
// - Forwarding bit 21 joins lower and upper
// - Upper base holds address bits 63:32
// - 64-bit disabled means no address translation
// - 64-bit addresses outside downstream window go upstream
// - Base bit writable only where setup bit set
`ifndef UM3W_DEFS_SVH
`define UM3W_DEFS_SVH
`define UM3W_OFF_LOWER_BASE 8'h60
`define UM3W_OFF_UPPER_BASE 8'h64
`define UM3W_OFF_FWD_CTRL 8'h68
`define UM3W_CSR_LOWER_SETUP 12'h034
`define UM3W_CSR_UPPER_SETUP 12'h038
`define UM3W_FWD_BIT_64 21
`define UM3W_SETUP_EN_BIT 31
`define UM3W_LOWER_RO_MASK 32'h00000FFF
`define UM3W_TYPE_32 2'h0
`define UM3W_TYPE_64 2'h1
`define UM3W_BASE_RESET 32'h00000000
`define UM3W_SETUP_RESET 32'h00000000
`endif

// ==== rtl/um3w_pkg.sv ====
// Types shared by the upstream memory window 3 decoder
package um3w_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } um3w_cfg_req_t;

  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } um3w_csr_req_t;

  typedef struct packed {
    logic valid;
    logic dac;
    logic [63:0] addr;
  } um3w_txn_t;
endpackage : um3w_pkg

// ==== test/um3w_checker.sv ====
// Port assertions for the window 3 decoder
`timescale 1ns/1ps
module um3w_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Watched ports
  input wire um3w_pkg::um3w_cfg_req_t cfg_req,
  input wire logic [31:0] cfg_rdata,
  input wire um3w_pkg::um3w_txn_t sec_txn,
  input wire logic [63:0] ds_mem3_base,
  input wire logic [63:0] ds_mem3_limit,
  input wire logic fwd_valid,
  input wire logic fwd_hit,
  input wire logic fwd_upstream
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire out_w = sec_txn.addr < ds_mem3_base || sec_txn.addr > ds_mem3_limit;
  sequence rd_lo; cfg_req.rd && cfg_req.addr == 8'h60; endsequence
  a_valid_echo: assert property (sec_txn.valid |=> fwd_valid)
    else $error("valid lost");
  a_idle_quiet: assert property (!sec_txn.valid |=> !fwd_valid && !fwd_hit
    && !fwd_upstream) else $error("idle output");
  a_dac_outside_up: assert property (
    sec_txn.valid && sec_txn.dac && out_w |=> fwd_upstream) else $error("no up");
  a_hit_goes_up: assert property (fwd_hit |-> fwd_upstream)
    else $error("hit not up");
  a_space_mem: assert property (
    rd_lo |=> cfg_rdata[0] == 1'b0 && cfg_rdata[11:4] == 8'h00) else $error("lo");
  a_type_legal: assert property (rd_lo |=> !cfg_rdata[2])
    else $error("type");
  a_noread_zero: assert property (!cfg_req.rd |=> cfg_rdata == 32'h00000000)
    else $error("idle data");
  a_unmapped_zero: assert property (cfg_req.rd && cfg_req.addr > 8'h68 |=>
    cfg_rdata == 32'h00000000) else $error("unmapped");
endmodule : um3w_checker
bind um3w_decode um3w_checker um3w_checker_inst (.ref_clk(ref_clk),
  .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .sec_txn(sec_txn),
  .ds_mem3_base(ds_mem3_base), .ds_mem3_limit(ds_mem3_limit),
  .fwd_valid(fwd_valid), .fwd_hit(fwd_hit), .fwd_upstream(fwd_upstream));

// ==== test/um3w_master.sv ====
// Secondary bus master issuing memory transactions
`timescale 1ns/1ps
module um3w_master (
  // Clock
  input wire logic ref_clk,
  // Transaction out
  output um3w_pkg::um3w_txn_t sec_txn
);
  initial sec_txn = '0;
  task automatic issue(input logic [63:0] a, input logic d);
    @(negedge ref_clk);
    sec_txn = '{1'b1, d, a};
    @(negedge ref_clk);
    // Released address is scrambled so stale values never match
    sec_txn = '{1'b0, 1'b0, ~a};
  endtask : issue
endmodule : um3w_master

// ==== test/tb_um3w_decode.sv ====
// Self-checking bench for the window 3 decoder
`timescale 1ns/1ps
module tb_um3w_decode;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic [63:0] ds_lo = 64'h0000000100000000;
  logic [63:0] ds_hi = 64'h00000001FFFFFFFF;
  um3w_pkg::um3w_cfg_req_t cfg = '0;
  um3w_pkg::um3w_csr_req_t csr = '0;
  um3w_pkg::um3w_txn_t txn;
  logic [31:0] rd_d, sr_d;
  logic v_o, h_o, u_o;
  int err_count = 0, n_checks = 0, cyc = 0;
  initial forever #12.5 ref_clk = ~ref_clk;
  um3w_master um3w_master_inst (.ref_clk(ref_clk), .sec_txn(txn));
  um3w_decode um3w_decode_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .cfg_req(cfg), .cfg_rdata(rd_d), .csr_req(csr), .csr_rdata(sr_d),
    .prefetch_strap(strap), .ds_mem3_base(ds_lo), .ds_mem3_limit(ds_hi),
    .sec_txn(txn), .fwd_valid(v_o), .fwd_hit(h_o), .fwd_upstream(u_o));
  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic cw(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk) cfg = '{1'b1, 1'b0, a, d};
    @(negedge ref_clk) cfg = '0;
  endtask : cw
  task automatic cr(input logic [7:0] a, input logic [31:0] e);
    @(negedge ref_clk) cfg = '{1'b0, 1'b1, a, 32'h00000000};
    @(negedge ref_clk) cfg = '0;
    chk(rd_d, e);
  endtask : cr
  task automatic sw(input logic [11:0] a, input logic [31:0] d);
    @(negedge ref_clk) csr = '{1'b1, a, d};
    @(negedge ref_clk) csr = '0;
  endtask : sw
  task automatic sr(input logic [11:0] a, input logic [31:0] e);
    @(negedge ref_clk) csr = '{1'b0, a, 32'h00000000};
    @(negedge ref_clk) csr = '0;
    chk(sr_d, e);
  endtask : sr
  task automatic tx(input logic [63:0] a, input logic [1:0] e,
                    input logic d = 1'b1);
    um3w_master_inst.issue(a, d);
    chk({29'h0, v_o, h_o, u_o}, {29'h0, 1'b1, e});
  endtask : tx
  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  always @(posedge ref_clk) if (++cyc == 400) begin
    err_count++;
    results;
  end
  initial begin
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    cr(8'h60, 32'h00000000);
    cr(8'h64, 32'h00000000);
    cr(8'h70, 32'h00000000);
    sr(12'h034, 32'h00000000);
    sw(12'h034, 32'hFFF00000);
    sw(12'h038, 32'hFFFFFFFF);
    sr(12'h034, 32'hFFF00000);
    sr(12'h038, 32'hFFFFFFFF);
    cw(8'h60, 32'hFFFFFFFF);
    cr(8'h60, 32'hFFF00000);
    cw(8'h64, 32'h00000001);
    cr(8'h64, 32'h00000001);
    cw(8'h68, 32'h00200000);
    cr(8'h68, 32'h00200000);
    strap = 1'b1;
    cr(8'h60, 32'hFFF0000A);
    tx(64'h00000001FFF00010, 2'b11);
    tx(64'h0000000100000010, 2'b00);
    tx(64'h0000000200000010, 2'b01);
    sw(12'h034, 32'h7FF00000);
    tx(64'h00000001FFF00010, 2'b00);
    cw(8'h68, 32'h00000000);
    sw(12'h034, 32'hFFF00000);
    cr(8'h60, 32'hFFF00008);
    tx(64'h00000001FFF00010, 2'b00);
    tx(64'h00000000FFF00010, 2'b11, 1'b0);
    tx(64'h0000000010000010, 2'b00, 1'b0);
    ds_hi = 64'h000000017FFFFFFF;
    tx(64'h00000001FFF00010, 2'b01);
    @(negedge ref_clk) rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    cr(8'h60, 32'h00000008);
    cr(8'h64, 32'h00000000);
    sr(12'h034, 32'h00000000);
    results;
  end
endmodule : tb_um3w_decode
